// ---- pkg/fsps_consts.svh ----
// constants for the flash self-programming sequencer
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH

// ==========================================================
// register offsets
`define FSPS_OFS_CTRL      8'h00
`define FSPS_OFS_PTR_LO    8'h01
`define FSPS_OFS_PTR_HI    8'h02
`define FSPS_OFS_DATA_LO   8'h03
`define FSPS_OFS_DATA_HI   8'h04
`define FSPS_OFS_LOCK      8'h05

// ==========================================================
// control/status field positions
`define FSPS_BIT_ENABLE    0
`define FSPS_BIT_ERASE     1
`define FSPS_BIT_PWRITE    2
`define FSPS_BIT_LOCKSET   3
`define FSPS_BIT_RWWRE     4
`define FSPS_BIT_RWWBUSY   6
`define FSPS_BIT_IRQEN     7
`define FSPS_CMD_LSB       1
`define FSPS_CMD_MSB       4

// ==========================================================
// reset values
`define FSPS_CTRL_RESET    8'h00
`define FSPS_PTR_RESET     16'h0000
`define FSPS_DATA_RESET    8'h00
`define FSPS_LOCK_RESET    8'hFF
`define FSPS_ERASED_WORD   16'hFFFF

// ==========================================================
// readback pointer values
`define FSPS_RB_FUSE_LOW   2'h0
`define FSPS_RB_LOCK       2'h1
`define FSPS_RB_FUSE_EXT   2'h2
`define FSPS_RB_FUSE_HIGH  2'h3

// ==========================================================
// timing
`define FSPS_ARM_SPM_CYCLES 3'h4
`define FSPS_ARM_LPM_CYCLES 3'h3
`define FSPS_CLK_PERIOD_NS  10
`define FSPS_PROG_MIN_NS    3700000
`define FSPS_PROG_MAX_NS    4500000

`endif

// ---- pkg/fsps_pkg.sv ----
// types for the flash self-programming sequencer
package fsps_pkg;

  typedef enum logic [2:0] {
    FSPS_ST_IDLE  = 3'b001,
    FSPS_ST_ARMED = 3'b010,
    FSPS_ST_BUSY  = 3'b100
  } fsps_state_e;

  // command bits 4..1 of the control register, enable bit excluded
  typedef enum logic [3:0] {
    FSPS_CMD_LOAD  = 4'b0000,
    FSPS_CMD_ERASE = 4'b0001,
    FSPS_CMD_WRITE = 4'b0010,
    FSPS_CMD_LOCK  = 4'b0100,
    FSPS_CMD_RWWRE = 4'b1000
  } fsps_cmd_e;

endpackage

// ---- logic/fsps_page_buffer.sv ----
// temporary page buffer with per-word loaded flags
`timescale 1ns/1ns
`include "fsps_consts.svh"
module fsps_page_buffer #(
  parameter int WORD_BITS = 6
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 clear,
  input  wire logic                 wr_en,
  input  wire logic [WORD_BITS-1:0] wr_idx,
  input  wire logic [15:0]          wr_data,
  input  wire logic [WORD_BITS-1:0] rd_idx,
  output logic      [15:0]          rd_data_ff,
  output logic                      any_loaded
);
  localparam int ENTRIES = 1 << WORD_BITS;

  logic [15:0]        mem_ff [ENTRIES];
  logic [ENTRIES-1:0] loaded_ff;

  assign any_loaded = |loaded_ff;

  // ==========================================================
  // storage
  // a loaded word is not overwritten: only the first load counts
  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
        loaded_ff[i] <= 1'b0;
        mem_ff[i]    <= `FSPS_ERASED_WORD;
      end else if (wr_en && !loaded_ff[i] &&
                   wr_idx == WORD_BITS'(i)) begin
        loaded_ff[i] <= 1'b1;
        mem_ff[i]    <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_ff <= `FSPS_ERASED_WORD;
    end else begin
      rd_data_ff <= mem_ff[rd_idx];
    end
  end

endmodule

// ---- logic/fsps_sequencer.sv ----
// flash self-programming sequencer: control, timing and readback
//
// Functional notes
// - pointer splits into word-in-page low part and page index high part
// - erase pattern plus store instruction within four cycles erases page
// - load pattern plus store writes data word into buffer entry
// - write pattern plus store programs buffer into the addressed page
// - lock-set pattern plus store takes lock data from low data reg
// - lock bits 5..2 programmed where data bit is zero, only if timely
// - lock setting ignores pointer and never blocks flash reads
// - operation page is latched at start; pointer may change afterwards
// - program reads address bytes, pointer bit 0 selects the byte
// - buffer clears after page write, read-enable command, and reset
// - eeprom write during page loading discards loaded buffer data
// - rww target keeps other section readable; other target halts cpu
// - ready interrupt asserted continuously while enable bit is clear
// - rww section blocked during erase or write; busy flag held
// - eeprom write blocks all commands and fuse or lock readback
// - pointer 1 with lock-set armed: load instruction returns lock bits
// - lock-set and enable clear on readback or on timeout
// - pointers 0, 3, 2 return fuse low, high and extended bytes
// - readback shows zero for programmed, one for unprogrammed bits
// - enable arms store for four cycles, held until erase/write ends
// - control writes outside the five command patterns only update the interrupt enable
// - erase, write and lock write last between 3.7 ms and 4.5 ms
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "fsps_consts.svh"
module fsps_sequencer #(
  parameter int          PAGE_WORD_BITS = 6,
  parameter int          RWW_PAGES      = 224,
  parameter int unsigned PROG_CYCLES    =
    (`FSPS_PROG_MIN_NS + `FSPS_CLK_PERIOD_NS - 1) / `FSPS_CLK_PERIOD_NS
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    spm_strobe,
  input  wire logic                    lpm_strobe,
  input  wire logic                    eeprom_write_busy,
  input  wire logic                    eeprom_write_start,
  input  wire logic [7:0]              fuse_low_byte,
  input  wire logic [7:0]              fuse_high_byte,
  input  wire logic [7:0]              fuse_extended_byte,
  output logic      [7:0]              lpm_rdata,
  output logic                         lpm_rdata_valid,
  output logic      [14:0]             lpm_word_addr,
  output logic                         pointer_byte_select,
  output logic                         rww_read_block,
  output logic                         cpu_halt,
  output logic                         ready_irq,
  output fsps_pkg::fsps_cmd_e          active_cmd,
  output logic      [14-PAGE_WORD_BITS:0] flash_page,
  input  wire logic [PAGE_WORD_BITS-1:0]  buf_rd_index,
  output logic      [15:0]             buf_rd_data,
  output logic                         op_done
);
  import fsps_pkg::*;

  localparam int PG_W  = 15 - PAGE_WORD_BITS;
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // ==========================================================
  // state
  fsps_state_e       state_ff;
  fsps_cmd_e         cmd_ff;
  logic [2:0]        arm_cnt_ff;
  logic [CNT_W-1:0]  op_cnt_ff;
  logic              irq_en_ff;
  logic              rww_busy_ff;
  logic [15:0]       ptr_ff;
  logic [7:0]        data_lo_ff;
  logic [7:0]        data_hi_ff;
  logic [7:0]        lock_ff;
  logic [7:0]        lock_data_ff;
  logic [PG_W-1:0]   page_ff;
  logic              op_rww_ff;
  logic [7:0]        reg_rdata_ff;
  logic [7:0]        lpm_rdata_ff;
  logic              lpm_valid_ff;

  logic              ctrl_wr;
  logic              pattern_ok;
  logic              cmd_accept;
  logic              in_arm;
  logic              spm_ok;
  logic              lpm_ok;
  logic              timeout;
  logic              start_prog;
  logic [PG_W-1:0]   tgt_page;
  logic              tgt_rww;
  logic              buf_clear;
  logic              buf_wr;
  logic              buf_loaded;
  logic              enable;
  logic [7:0]        ctrl_view;
  logic [7:0]        rb_value;

  // ==========================================================
  // decode
  assign ctrl_wr    = reg_wr && reg_addr == `FSPS_OFS_CTRL;
  assign pattern_ok = reg_wdata[`FSPS_BIT_ENABLE] &&
    (reg_wdata[`FSPS_CMD_MSB:`FSPS_CMD_LSB] inside
      {FSPS_CMD_LOAD, FSPS_CMD_ERASE, FSPS_CMD_WRITE,
       FSPS_CMD_LOCK, FSPS_CMD_RWWRE});
  // a new command is only taken from idle and with no eeprom write
  assign cmd_accept = ctrl_wr && pattern_ok && state_ff == FSPS_ST_IDLE
                      && !eeprom_write_busy;
  assign in_arm     = state_ff == FSPS_ST_ARMED;
  assign spm_ok     = in_arm && spm_strobe && !eeprom_write_busy;
  // readback window is one cycle shorter than the store window
  assign lpm_ok     = in_arm && lpm_strobe && cmd_ff == FSPS_CMD_LOCK
    && !eeprom_write_busy
    && arm_cnt_ff > (`FSPS_ARM_SPM_CYCLES - `FSPS_ARM_LPM_CYCLES);
  assign timeout    = in_arm && arm_cnt_ff == 3'h1 && !spm_ok
                      && !lpm_ok;
  assign start_prog = spm_ok && (cmd_ff == FSPS_CMD_ERASE ||
    cmd_ff == FSPS_CMD_WRITE || cmd_ff == FSPS_CMD_LOCK);
  assign tgt_page   = ptr_ff[15:PAGE_WORD_BITS+1];
  assign tgt_rww    = tgt_page < PG_W'(RWW_PAGES);
  assign op_done    = state_ff == FSPS_ST_BUSY &&
                      op_cnt_ff == CNT_W'(1);
  assign enable     = state_ff != FSPS_ST_IDLE;

  // ==========================================================
  // sequence state and arm window
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff   <= FSPS_ST_IDLE;
      arm_cnt_ff <= 3'h0;
    end else begin
      case (state_ff)
        FSPS_ST_IDLE: begin
          if (cmd_accept) begin
            state_ff   <= FSPS_ST_ARMED;
            arm_cnt_ff <= `FSPS_ARM_SPM_CYCLES;
          end
        end
        FSPS_ST_ARMED: begin
          arm_cnt_ff <= arm_cnt_ff - 3'h1;
          if (start_prog) begin
            state_ff <= FSPS_ST_BUSY;
          end else if (spm_ok || lpm_ok || timeout) begin
            state_ff <= FSPS_ST_IDLE;
          end
        end
        FSPS_ST_BUSY: begin
          if (op_done) begin
            state_ff <= FSPS_ST_IDLE;
          end
        end
        default: begin
          state_ff <= FSPS_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // command bits and interrupt enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_ff    <= FSPS_CMD_LOAD;
      irq_en_ff <= 1'b0;
    end else begin
      // interrupt enable follows every control write, even when busy
      if (ctrl_wr) begin
        irq_en_ff <= reg_wdata[`FSPS_BIT_IRQEN];
      end
      if (cmd_accept) begin
        cmd_ff <= fsps_cmd_e'(reg_wdata[`FSPS_CMD_MSB:`FSPS_CMD_LSB]);
      end else if ((in_arm && (spm_ok || lpm_ok || timeout) &&
                    !start_prog) || op_done) begin
        cmd_ff <= FSPS_CMD_LOAD;
      end
    end
  end

  // ==========================================================
  // programming timer and latched target
  // the timer runs on the system clock at the minimum duration, so it stays
  // inside the allowed window only at the nominal clock or a slightly slower one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_cnt_ff    <= '0;
      page_ff      <= '0;
      op_rww_ff    <= 1'b0;
      lock_data_ff <= 8'hFF;
    end else if (start_prog) begin
      op_cnt_ff    <= CNT_W'(PROG_CYCLES);
      page_ff      <= tgt_page;
      // lock writes touch no section, so they never block reads
      op_rww_ff    <= cmd_ff != FSPS_CMD_LOCK && tgt_rww;
      lock_data_ff <= data_lo_ff;
    end else if (state_ff == FSPS_ST_BUSY) begin
      op_cnt_ff <= op_cnt_ff - CNT_W'(1);
    end
  end

  // ==========================================================
  // lock bits: only bits 5..2 can be programmed, never unprogrammed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_ff <= `FSPS_LOCK_RESET;
    end else if (op_done && cmd_ff == FSPS_CMD_LOCK) begin
      lock_ff[5:2] <= lock_ff[5:2] & lock_data_ff[5:2];
    end
  end

  // ==========================================================
  // read-while-write busy flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rww_busy_ff <= 1'b0;
    end else if (start_prog && cmd_ff != FSPS_CMD_LOCK && tgt_rww) begin
      rww_busy_ff <= 1'b1;
    end else if (spm_ok && (cmd_ff == FSPS_CMD_RWWRE ||
                            cmd_ff == FSPS_CMD_LOAD)) begin
      rww_busy_ff <= 1'b0;
    end
  end

  assign rww_read_block = rww_busy_ff;
  assign cpu_halt   = state_ff == FSPS_ST_BUSY && !op_rww_ff &&
                      cmd_ff != FSPS_CMD_LOCK;
  assign ready_irq  = irq_en_ff && !enable;
  assign active_cmd = cmd_ff;
  assign flash_page = page_ff;

  // ==========================================================
  // temporary page buffer
  assign buf_wr    = spm_ok && cmd_ff == FSPS_CMD_LOAD;
  assign buf_clear = (op_done && cmd_ff == FSPS_CMD_WRITE)
    || (spm_ok && cmd_ff == FSPS_CMD_RWWRE)
    || (eeprom_write_start && buf_loaded);

  fsps_page_buffer #(
    .WORD_BITS (PAGE_WORD_BITS)
  ) u_buf (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .clear      (buf_clear),
    .wr_en      (buf_wr),
    .wr_idx     (ptr_ff[PAGE_WORD_BITS:1]),
    .wr_data    ({data_hi_ff, data_lo_ff}),
    .rd_idx     (buf_rd_index),
    .rd_data_ff (buf_rd_data),
    .any_loaded (buf_loaded)
  );

  // ==========================================================
  // pointer and data registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_ff     <= `FSPS_PTR_RESET;
      data_lo_ff <= `FSPS_DATA_RESET;
      data_hi_ff <= `FSPS_DATA_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `FSPS_OFS_PTR_LO:  ptr_ff[7:0]  <= reg_wdata;
        `FSPS_OFS_PTR_HI:  ptr_ff[15:8] <= reg_wdata;
        `FSPS_OFS_DATA_LO: data_lo_ff   <= reg_wdata;
        `FSPS_OFS_DATA_HI: data_hi_ff   <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign lpm_word_addr       = ptr_ff[15:1];
  assign pointer_byte_select = ptr_ff[0];

  // ==========================================================
  // fuse and lock readback, raw: programmed bits read as zero
  always_comb begin
    case (ptr_ff[1:0])
      `FSPS_RB_FUSE_LOW:  rb_value = fuse_low_byte;
      `FSPS_RB_LOCK:      rb_value = lock_ff;
      `FSPS_RB_FUSE_EXT:  rb_value = fuse_extended_byte;
      `FSPS_RB_FUSE_HIGH: rb_value = fuse_high_byte;
      default:            rb_value = 8'hFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lpm_rdata_ff <= 8'h00;
      lpm_valid_ff <= 1'b0;
    end else begin
      lpm_valid_ff <= lpm_ok;
      if (lpm_ok) begin
        lpm_rdata_ff <= rb_value;
      end
    end
  end

  assign lpm_rdata       = lpm_rdata_ff;
  assign lpm_rdata_valid = lpm_valid_ff;

  // ==========================================================
  // register read port
  assign ctrl_view = {irq_en_ff, rww_busy_ff, 1'b0, cmd_ff, enable};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FSPS_OFS_CTRL:    reg_rdata_ff <= ctrl_view;
        `FSPS_OFS_PTR_LO:  reg_rdata_ff <= ptr_ff[7:0];
        `FSPS_OFS_PTR_HI:  reg_rdata_ff <= ptr_ff[15:8];
        `FSPS_OFS_DATA_LO: reg_rdata_ff <= data_lo_ff;
        `FSPS_OFS_DATA_HI: reg_rdata_ff <= data_hi_ff;
        `FSPS_OFS_LOCK:    reg_rdata_ff <= lock_ff;
        default:           reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_arm_window;
    cmd_accept |=> in_arm ##0 (1'b1 ##[1:4] !in_arm);
  endproperty
  a_arm_window: assert property (p_arm_window)
    else $error("arm window exceeded four cycles");

  property p_bad_pattern;
    (ctrl_wr && !pattern_ok && state_ff == FSPS_ST_IDLE) |=>
      state_ff == FSPS_ST_IDLE;
  endproperty
  a_bad_pattern: assert property (p_bad_pattern)
    else $error("invalid control pattern started a sequence");

  property p_ee_blocks;
    (ctrl_wr && eeprom_write_busy && state_ff == FSPS_ST_IDLE) |=>
      state_ff == FSPS_ST_IDLE;
  endproperty
  a_ee_blocks: assert property (p_ee_blocks)
    else $error("command taken during eeprom write");

  property p_busy_ignores;
    (state_ff == FSPS_ST_BUSY && !op_done) |=>
      $stable(cmd_ff) && $stable(page_ff);
  endproperty
  a_busy_ignores: assert property (p_busy_ignores)
    else $error("command or page changed during operation");

  property p_prog_length;
    $fell(state_ff == FSPS_ST_BUSY) |->
      $past(op_cnt_ff) == CNT_W'(1) && $past(op_done);
  endproperty
  a_prog_length: assert property (p_prog_length)
    else $error("operation ended before its timer");

  property p_prog_start;
    start_prog |=> state_ff == FSPS_ST_BUSY &&
      op_cnt_ff == CNT_W'(PROG_CYCLES) && page_ff == $past(tgt_page);
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("operation did not latch page and timer");

  property p_irq;
    (irq_en_ff && state_ff == FSPS_ST_IDLE) |-> ready_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("ready interrupt missing while enable clear");

  property p_rww_block;
    (state_ff == FSPS_ST_BUSY && op_rww_ff) |->
      rww_read_block && !cpu_halt;
  endproperty
  a_rww_block: assert property (p_rww_block)
    else $error("rww target not blocked or cpu halted");

  property p_lock_no_halt;
    (state_ff == FSPS_ST_BUSY && cmd_ff == FSPS_CMD_LOCK) |-> !cpu_halt;
  endproperty
  a_lock_no_halt: assert property (p_lock_no_halt)
    else $error("cpu halted during lock write");

  property p_readback;
    lpm_ok |=> lpm_rdata_valid && lpm_rdata == $past(rb_value) &&
      !enable && cmd_ff == FSPS_CMD_LOAD;
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback value or clearing wrong");

  property p_buf_cleared;
    (op_done && cmd_ff == FSPS_CMD_WRITE) |=> ##1 !buf_loaded;
  endproperty
  a_buf_cleared: assert property (p_buf_cleared)
    else $error("buffer not cleared after page write");

  c_erase_done: cover property (op_done && cmd_ff == FSPS_CMD_ERASE);
  c_load:       cover property (buf_wr);
  c_lock_read:  cover property (lpm_ok && ptr_ff[1:0] == `FSPS_RB_LOCK);
  c_timeout:    cover property (timeout);

endmodule

// ---- dv/fsps_core_model.sv ----
// core-side model: store and load program-memory strobes after a lag
`timescale 1ns/1ns
module fsps_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       spm_req,
  input  wire logic       lpm_req,
  input  wire logic [2:0] lag,
  output logic            spm_strobe,
  output logic            lpm_strobe
);
  logic [2:0] cnt_ff;
  logic       wait_ff;
  logic       kind_ff;
  // ==========================================
  // strobe timing
  // lag 0 answers in the cycle after the control write, lag 4 is late
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_ff <= 1'b0;
    end else if (spm_req | lpm_req) begin
      wait_ff <= 1'b1;
      cnt_ff  <= lag;
      kind_ff <= lpm_req;
    end else if (cnt_ff == 3'h0) begin
      wait_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end
  assign spm_strobe = wait_ff && cnt_ff == 3'h0 && !kind_ff;
  assign lpm_strobe = wait_ff && cnt_ff == 3'h0 && kind_ff;
endmodule

// ---- dv/fsps_sequencer_test.sv ----
// self-checking testbench for the flash self-programming sequencer
`timescale 1ns/1ns
module fsps_sequencer_test;
  import fsps_pkg::*;
  localparam int P = 20;
  logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        eeprom_write_busy = 1'b0, eeprom_write_start = 1'b0;
  logic        spm_req = 1'b0, lpm_req = 1'b0;
  logic [2:0]  lag = 3'h0;
  logic [5:0]  buf_rd_index = 6'h00;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0]  fuse_low_byte = 8'hA5, fuse_high_byte = 8'h3C;
  logic [7:0]  fuse_extended_byte = 8'hF6, reg_rdata, lpm_rdata;
  logic [7:0]  rb [4] = '{8'hA5, 8'hFF, 8'hF6, 8'h3C};
  logic [14:0] lpm_word_addr;
  logic [8:0]  flash_page;
  logic [15:0] buf_rd_data;
  logic        spm_strobe, lpm_strobe, lpm_rdata_valid, op_done;
  logic        pointer_byte_select, rww_read_block, cpu_halt, ready_irq;
  fsps_cmd_e   active_cmd;
  int          bad_count = 0, compares = 0, cyc = 0, t0 = 0, nv = 0;

  fsps_sequencer #(.PROG_CYCLES(P)) dut_u (.*);
  fsps_core_model core_u (.*);

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // bounded run: a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (lpm_rdata_valid === 1'b1) begin
      nv <= nv + 1;
    end
    if (cyc == 3000) begin
      bad_count++;
      finish_test;
    end
  end
  // ==========================================
  // access tasks
  task automatic tk;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    tk;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tk;
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, e);
    tk;
    reg_addr <= a;
    reg_rd <= 1'b1;
    tk;
    reg_rd <= 1'b0;
    chk(n, 16'(e), 16'(reg_rdata));
  endtask
  task automatic bc(input logic [5:0] i, input logic [15:0] e);
    tk;
    buf_rd_index <= i;
    tk;
    chk("buffer", e, buf_rd_data);
  endtask
  // control write, then a store or load strobe after lag cycles
  task automatic cmd(input logic [7:0] c, input logic s, input logic [2:0] l);
    tk;
    reg_addr <= 8'h00;
    reg_wdata <= c;
    reg_wr <= 1'b1;
    spm_req <= s;
    lpm_req <= ~s;
    lag <= l;
    tk;
    t0 = cyc;
    reg_wr <= 1'b0;
    spm_req <= 1'b0;
    lpm_req <= 1'b0;
    repeat (4) tk;
  endtask
  task automatic fin(input int l);
    int n;
    n = 0;
    while (op_done !== 1'b1 && n < 100) begin
      tk;
      n++;
    end
    chk("duration", 16'(P + l), 16'(cyc - t0));
    tk;
  endtask
  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // test sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rc("ctrl", 8'h00, 8'h00);
    rc("lock", 8'h05, 8'hFF);
    rc("unmapped", 8'h3A, 8'h00);
    bc(6'h05, 16'hFFFF);
    $display("reset test ends");
    wr(8'h01, 8'h0B);
    wr(8'h03, 8'h34);
    wr(8'h04, 8'h12);
    chk("word", 16'h0005, 16'(lpm_word_addr));
    chk("byte", 16'h0001, 16'(pointer_byte_select));
    cmd(8'h01, 1'b1, 3'h3);
    bc(6'h05, 16'h1234);
    wr(8'h01, 8'h0C);
    cmd(8'h01, 1'b1, 3'h4);
    bc(6'h06, 16'hFFFF);
    wr(8'h00, 8'h87);
    rc("ctrl", 8'h00, 8'h80);
    chk("irq", 16'h0001, 16'(ready_irq));
    $display("load test ends");
    wr(8'h01, 8'h80);
    wr(8'h02, 8'h01);
    cmd(8'h83, 1'b1, 3'h0);
    wr(8'h02, 8'h00);
    chk("page", 16'h0003, 16'(flash_page));
    chk("rww", 16'h0001, 16'(rww_read_block));
    chk("irq", 16'h0000, 16'(ready_irq));
    wr(8'h00, 8'h85);
    chk("cmd", 16'h0001, 16'(active_cmd));
    rc("ctrl", 8'h00, 8'hC3);
    fin(0);
    rc("ctrl", 8'h00, 8'hC0);
    cmd(8'h11, 1'b1, 3'h0);
    rc("ctrl", 8'h00, 8'h00);
    wr(8'h01, 8'h04);
    wr(8'h03, 8'hEF);
    wr(8'h04, 8'hBE);
    cmd(8'h01, 1'b1, 3'h1);
    bc(6'h02, 16'hBEEF);
    cmd(8'h11, 1'b1, 3'h2);
    bc(6'h02, 16'hFFFF);
    $display("erase test ends");
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h73);
    cmd(8'h01, 1'b1, 3'h0);
    cmd(8'h05, 1'b1, 3'h2);
    chk("page", 16'h00E6, 16'(flash_page));
    chk("halt", 16'h0001, 16'(cpu_halt));
    chk("rww", 16'h0000, 16'(rww_read_block));
    fin(2);
    bc(6'h00, 16'hFFFF);
    $display("write test ends");
    wr(8'h01, 8'h02);
    cmd(8'h01, 1'b1, 3'h0);
    eeprom_write_start <= 1'b1;
    tk;
    eeprom_write_start <= 1'b0;
    bc(6'h01, 16'hFFFF);
    eeprom_write_busy <= 1'b1;
    cmd(8'h01, 1'b1, 3'h0);
    cmd(8'h09, 1'b0, 3'h0);
    eeprom_write_busy <= 1'b0;
    bc(6'h01, 16'hFFFF);
    chk("lpm", 16'h0000, 16'(lpm_rdata));
    $display("eeprom test ends");
    wr(8'h02, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, 8'(i));
      cmd(8'h09, 1'b0, 3'h2);
      chk("fuse", 16'(rb[i]), 16'(lpm_rdata));
      rc("ctrl", 8'h00, 8'h00);
    end
    wr(8'h01, 8'h00);
    cmd(8'h09, 1'b0, 3'h3);
    chk("late", 16'h003C, 16'(lpm_rdata));
    chk("valid", 16'h0004, 16'(nv));
    $display("readback test ends");
    wr(8'h01, 8'h80);
    wr(8'h03, 8'hF3);
    cmd(8'h09, 1'b1, 3'h3);
    chk("rww", 16'h0000, 16'(rww_read_block));
    chk("halt", 16'h0000, 16'(cpu_halt));
    fin(3);
    rc("lock", 8'h05, 8'hF3);
    $display("lock test ends");
    finish_test;
  end
endmodule
